/* apsr_map.svh */
// Register offsets, field positions, reset values and timing counts for the converter control block
`ifndef APSR_MAP_SVH
`define APSR_MAP_SVH

// ============================================================
// Register byte offsets (one aligned word each)
`define APSR_OFF_CTRL_ONE 4'h0
`define APSR_OFF_STPT_HIGH 4'h4
`define APSR_OFF_STPT_LOW 4'h8
`define APSR_OFF_ERR_HIGH 4'hC

// ============================================================
// Control register one field positions
`define APSR_BIT_DSEN 0
`define APSR_BIT_GPOL 5
`define APSR_BIT_IPEN 6
`define APSR_BIT_PPOL 7
// Implemented bits of control register one
`define APSR_CTRL_ONE_MASK 8'hE1

// ============================================================
// Reset values
`define APSR_RST_CTRL_ONE 8'h00
`define APSR_RST_STPT 8'h00

// ============================================================
// Timing counts: conversion length in clock cycles
`define APSR_CONV_CYCLES 4'hA

`endif

/* apsr_pkg.sv */
// Types shared by the converter control block
`default_nettype none
package apsr_pkg;

    // ============================================================
    // Conversion sequencer states
    typedef enum logic [2:0] {
        APSR_IDLE,
        APSR_PRE1,
        APSR_CONV1,
        APSR_PRE2,
        APSR_CONV2
    } apsr_state_t;

endpackage : apsr_pkg
`default_nettype wire

/* apsr_sequencer.sv */
// Conversion sequencer: single or double sampling with precharge and guard polarity
`timescale 1ns/1ps
`default_nettype none
`include "apsr_map.svh"

module apsr_sequencer (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Configuration
    input wire logic double_sample_enable,
    input wire logic inverted_precharge_enable,
    input wire logic precharge_polarity,
    input wire logic guard_polarity,
    input wire logic [7:0] precharge_time,
    // Trigger and conversion data
    input wire logic trigger,
    input wire logic [15:0] sample,
    // Sequencer state and results
    output logic busy,
    output logic conv_done,
    output logic second_cycle,
    output logic precharge_active,
    output logic pin_to_supply,
    output logic hold_to_supply,
    output logic guard_level,
    output logic [15:0] result,
    output logic [15:0] previous_result
);

    // ============================================================
    // State
    apsr_pkg::apsr_state_t state_ff; // Sequencer state
    apsr_pkg::apsr_state_t nxt_state;
    logic [7:0] cnt_ff; // Stage cycle counter
    logic invert_ff; // Polarity flip for second cycle
    logic pin_sup_ff;
    logic hold_sup_ff;
    logic guard_ff;
    logic done_ff;
    logic [15:0] result_ff;
    logic [15:0] prev_ff;
    logic stage_end;

    // Effective polarity after optional inversion
    logic eff_ppol;
    logic eff_gpol;
    assign eff_ppol = precharge_polarity ^ invert_ff;
    assign eff_gpol = guard_polarity ^ invert_ff;
    assign stage_end = (cnt_ff == 8'h00);

    // ============================================================
    // Next state
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            apsr_pkg::APSR_IDLE: begin
                // Zero precharge time skips the precharge stage
                if (trigger) begin
                    nxt_state = (precharge_time != 8'h00) ? apsr_pkg::APSR_PRE1
                                                         : apsr_pkg::APSR_CONV1;
                end
            end
            apsr_pkg::APSR_PRE1: begin
                if (stage_end) begin
                    nxt_state = apsr_pkg::APSR_CONV1;
                end
            end
            apsr_pkg::APSR_CONV1: begin
                if (stage_end) begin
                    // Second conversion only when double sampling
                    if (!double_sample_enable) begin
                        nxt_state = apsr_pkg::APSR_IDLE;
                    end else if (precharge_time != 8'h00) begin
                        nxt_state = apsr_pkg::APSR_PRE2;
                    end else begin
                        nxt_state = apsr_pkg::APSR_CONV2;
                    end
                end
            end
            apsr_pkg::APSR_PRE2: begin
                if (stage_end) begin
                    nxt_state = apsr_pkg::APSR_CONV2;
                end
            end
            apsr_pkg::APSR_CONV2: begin
                if (stage_end) begin
                    nxt_state = apsr_pkg::APSR_IDLE;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= apsr_pkg::APSR_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Stage counter reloads on every state change
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_ff <= 8'h00;
        end else if (nxt_state != state_ff) begin
            if (nxt_state == apsr_pkg::APSR_PRE1 || nxt_state == apsr_pkg::APSR_PRE2) begin
                cnt_ff <= precharge_time - 8'h01;
            end else begin
                cnt_ff <= {4'h0, `APSR_CONV_CYCLES} - 8'h01;
            end
        end else if (!stage_end) begin
            cnt_ff <= cnt_ff - 8'h01;
        end
    end

    // Inversion applies only to the second cycle of a double sample
    always_ff @(posedge clk) begin
        if (rst) begin
            invert_ff <= 1'b0;
        end else if (state_ff == apsr_pkg::APSR_CONV1 && stage_end) begin
            invert_ff <= double_sample_enable & inverted_precharge_enable;
        end else if (nxt_state == apsr_pkg::APSR_IDLE) begin
            invert_ff <= 1'b0;
        end
    end

    // Precharge switch and guard drive; held at reset level outside precharge
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_sup_ff <= 1'b0;
            hold_sup_ff <= 1'b0;
            guard_ff <= 1'b0;
        end else if (state_ff == apsr_pkg::APSR_PRE1 || state_ff == apsr_pkg::APSR_PRE2) begin
            // Polarity 1 ties pin to supply and hold cap to ground
            pin_sup_ff <= eff_ppol;
            hold_sup_ff <= ~eff_ppol;
            // Guard starts at the selected level
            guard_ff <= eff_gpol;
        end else begin
            pin_sup_ff <= 1'b0;
            hold_sup_ff <= 1'b0;
            guard_ff <= 1'b0;
        end
    end

    // Result capture; first of a pair moves to previous result
    always_ff @(posedge clk) begin
        if (rst) begin
            result_ff <= 16'h0000;
            prev_ff <= 16'h0000;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (state_ff == apsr_pkg::APSR_CONV1 && stage_end) begin
                result_ff <= sample;
                if (double_sample_enable) begin
                    prev_ff <= sample;
                end else begin
                    done_ff <= 1'b1;
                end
            end else if (state_ff == apsr_pkg::APSR_CONV2 && stage_end) begin
                result_ff <= sample;
                done_ff <= 1'b1;
            end
        end
    end

    // ============================================================
    // Outputs
    assign busy = (state_ff != apsr_pkg::APSR_IDLE);
    assign second_cycle = invert_ff | (state_ff == apsr_pkg::APSR_PRE2)
                        | (state_ff == apsr_pkg::APSR_CONV2);
    assign precharge_active = (state_ff == apsr_pkg::APSR_PRE1)
                            | (state_ff == apsr_pkg::APSR_PRE2);
    assign conv_done = done_ff;
    assign pin_to_supply = pin_sup_ff;
    assign hold_to_supply = hold_sup_ff;
    assign guard_level = guard_ff;
    assign result = result_ff;
    assign previous_result = prev_ff;

    // ============================================================
    // Assertions
    property p_single_no_second;
        @(posedge clk) disable iff (rst)
        (state_ff == apsr_pkg::APSR_CONV1 && stage_end && !double_sample_enable)
            |=> state_ff == apsr_pkg::APSR_IDLE;
    endproperty
    a_single_no_second: assert property (p_single_no_second)
        else $error("single sample ran a second conversion");

    property p_double_second;
        @(posedge clk) disable iff (rst)
        (state_ff == apsr_pkg::APSR_CONV1 && stage_end && double_sample_enable)
            |=> (state_ff == apsr_pkg::APSR_PRE2 || state_ff == apsr_pkg::APSR_CONV2)
                && prev_ff == $past(sample);
    endproperty
    a_double_second: assert property (p_double_second)
        else $error("double sample missed second conversion or previous result");

    property p_invert_second;
        @(posedge clk) disable iff (rst)
        (state_ff == apsr_pkg::APSR_PRE2 && invert_ff)
            |=> pin_sup_ff == ~$past(precharge_polarity) && guard_ff == ~$past(guard_polarity);
    endproperty
    a_invert_second: assert property (p_invert_second)
        else $error("second cycle polarity not inverted");

    property p_no_invert_first;
        @(posedge clk) disable iff (rst)
        (state_ff == apsr_pkg::APSR_PRE1)
            |=> pin_sup_ff == $past(precharge_polarity) && hold_sup_ff != pin_sup_ff;
    endproperty
    a_no_invert_first: assert property (p_no_invert_first)
        else $error("first cycle precharge polarity wrong");

    property p_guard_start;
        @(posedge clk) disable iff (rst)
        (state_ff == apsr_pkg::APSR_PRE1) |=> guard_ff == $past(guard_polarity);
    endproperty
    a_guard_start: assert property (p_guard_start)
        else $error("guard ring start level wrong");

endmodule : apsr_sequencer
`default_nettype wire

/* apsr_top.sv */
// Converter control top: Avalon-MM registers, setpoint, setpoint error and sequencer
`timescale 1ns/1ps
`default_nettype none
`include "apsr_map.svh"


module apsr_top #(
    parameter int ERR_MODE_W = 3 // Width of computation mode select
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET,
    // Avalon-MM slave
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // Converter side
    input wire logic TRIGGER,
    input wire logic [15:0] SAMPLE,
    input wire logic [7:0] PRECHARGE_TIME,
    input wire logic [ERR_MODE_W-1:0] COMPUTATION_MODE_SELECT,
    // Converter status and drive
    output logic BUSY,
    output logic CONV_DONE,
    output logic SECOND_CYCLE,
    output logic PRECHARGE_ACTIVE,
    output logic PIN_TO_SUPPLY,
    output logic HOLD_TO_SUPPLY,
    output logic GUARD_LEVEL,
    output logic [15:0] RESULT,
    output logic [15:0] PREVIOUS_RESULT
);

    // ============================================================
    // Registers
    logic [7:0] ctrl_one_ff; // Control register one, implemented bits only
    logic [7:0] stpt_high_ff; // Threshold setpoint upper byte
    logic [7:0] stpt_low_ff; // Threshold setpoint lower byte
    logic [7:0] err_high_ff; // Setpoint error upper byte
    logic [31:0] rdata_ff; // Registered read data
    logic ack_ff; // One-cycle answer strobe
    logic [31:0] nxt_rdata;
    logic wr_go;
    logic rd_go;
    logic [15:0] setpoint;
    logic [15:0] err_value;

    // Access accepted once, the cycle after the request appears
    assign wr_go = AVS_WRITE & ack_ff;
    assign rd_go = AVS_READ & ack_ff;
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_ff;
    assign setpoint = {stpt_high_ff, stpt_low_ff};

    // Match helper for address decode
    function automatic logic hit(input logic [3:0] addr, input logic [3:0] off);
        hit = (addr == off);
    endfunction : hit

    // ============================================================
    // Handshake: every access takes one wait state, giving read data a flop
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= (AVS_READ | AVS_WRITE) & ~ack_ff;
        end
    end

    // Control register one; unimplemented bits never store
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            ctrl_one_ff <= `APSR_RST_CTRL_ONE;
        end else if (wr_go && AVS_BYTEENABLE[0] && hit(AVS_ADDRESS, `APSR_OFF_CTRL_ONE)) begin
            ctrl_one_ff <= AVS_WRITEDATA[7:0] & `APSR_CTRL_ONE_MASK;
        end
    end

    // Setpoint bytes, software read and write
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            stpt_high_ff <= `APSR_RST_STPT;
            stpt_low_ff <= `APSR_RST_STPT;
        end else if (wr_go && AVS_BYTEENABLE[0]) begin
            if (hit(AVS_ADDRESS, `APSR_OFF_STPT_HIGH)) begin
                stpt_high_ff <= AVS_WRITEDATA[7:0];
            end
            if (hit(AVS_ADDRESS, `APSR_OFF_STPT_LOW)) begin
                stpt_low_ff <= AVS_WRITEDATA[7:0];
            end
        end
    end

    // ============================================================
    // Setpoint error by mode; a small stand-in for the mode logic outside
    always_comb begin
        unique case (COMPUTATION_MODE_SELECT[1:0])
            2'h0: err_value = RESULT - PREVIOUS_RESULT;
            2'h1: err_value = RESULT - setpoint;
            2'h2: err_value = PREVIOUS_RESULT - setpoint;
            2'h3: err_value = setpoint - RESULT;
        endcase
    end

    // Error byte updates on conversion done only; bus writes never reach it
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            err_high_ff <= 8'h00;
        end else if (CONV_DONE) begin
            err_high_ff <= err_value[15:8];
        end
    end

    // ============================================================
    // Read mux; unmapped offsets read zero
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (hit(AVS_ADDRESS, `APSR_OFF_CTRL_ONE)) begin
            nxt_rdata = {24'h00_0000, ctrl_one_ff & `APSR_CTRL_ONE_MASK};
        end else if (hit(AVS_ADDRESS, `APSR_OFF_STPT_HIGH)) begin
            nxt_rdata = {24'h00_0000, stpt_high_ff};
        end else if (hit(AVS_ADDRESS, `APSR_OFF_STPT_LOW)) begin
            nxt_rdata = {24'h00_0000, stpt_low_ff};
        end else if (hit(AVS_ADDRESS, `APSR_OFF_ERR_HIGH)) begin
            nxt_rdata = {24'h00_0000, err_high_ff};
        end
    end

    // Read data flop loads in the wait cycle and stands through the ack
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            rdata_ff <= 32'h0000_0000;
        end else if (AVS_READ && !ack_ff) begin
            rdata_ff <= nxt_rdata;
        end
    end
    assign AVS_READDATA = rdata_ff;

    // ============================================================
    // Sequencer
    apsr_sequencer u_seq (
        .clk(CORE_CLK),
        .rst(RESET),
        .double_sample_enable(ctrl_one_ff[`APSR_BIT_DSEN]),
        .inverted_precharge_enable(ctrl_one_ff[`APSR_BIT_IPEN]),
        .precharge_polarity(ctrl_one_ff[`APSR_BIT_PPOL]),
        .guard_polarity(ctrl_one_ff[`APSR_BIT_GPOL]),
        .precharge_time(PRECHARGE_TIME),
        .trigger(TRIGGER),
        .sample(SAMPLE),
        .busy(BUSY),
        .conv_done(CONV_DONE),
        .second_cycle(SECOND_CYCLE),
        .precharge_active(PRECHARGE_ACTIVE),
        .pin_to_supply(PIN_TO_SUPPLY),
        .hold_to_supply(HOLD_TO_SUPPLY),
        .guard_level(GUARD_LEVEL),
        .result(RESULT),
        .previous_result(PREVIOUS_RESULT)
    );

    // ============================================================
    // Assertions
    property p_reserved_zero;
        @(posedge CORE_CLK) disable iff (RESET)
        (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == `APSR_OFF_CTRL_ONE)
            |-> AVS_READDATA[4:1] == 4'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved control bits read nonzero");

    property p_stpt_high_wr;
        @(posedge CORE_CLK) disable iff (RESET)
        (wr_go && AVS_BYTEENABLE[0] && AVS_ADDRESS == `APSR_OFF_STPT_HIGH)
            |=> stpt_high_ff == $past(AVS_WRITEDATA[7:0]);
    endproperty
    a_stpt_high_wr: assert property (p_stpt_high_wr)
        else $error("high setpoint write lost");

    property p_stpt_low_wr;
        @(posedge CORE_CLK) disable iff (RESET)
        (wr_go && AVS_BYTEENABLE[0] && AVS_ADDRESS == `APSR_OFF_STPT_LOW)
            |=> stpt_low_ff == $past(AVS_WRITEDATA[7:0]);
    endproperty
    a_stpt_low_wr: assert property (p_stpt_low_wr)
        else $error("low setpoint write lost");

    property p_err_ro;
        @(posedge CORE_CLK) disable iff (RESET)
        (!CONV_DONE) |=> $stable(err_high_ff);
    endproperty
    a_err_ro: assert property (p_err_ro)
        else $error("setpoint error changed without conversion");

endmodule : apsr_top
`default_nettype wire

/* apsr_tb.sv */
// Self-checking testbench for the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "apsr_map.svh"

module tb;
    // ============================================================
    // Bench signals
    // Clock and reset
    logic core_clk;
    logic reset;
    // Register bus
    logic [3:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    // Converter side
    logic trigger;
    logic [15:0] sample;
    logic [7:0] precharge_time;
    logic [2:0] computation_mode_select;
    logic busy;
    logic conv_done;
    logic second_cycle;
    logic precharge_active;
    logic pin_to_supply;
    logic hold_to_supply;
    logic guard_level;
    logic [15:0] result;
    logic [15:0] previous_result;
    // Scoreboard
    int n_fail;
    int checks_done;
    logic [31:0] rd;

    apsr_top #(.ERR_MODE_W(3)) dut (
        .CORE_CLK(core_clk), .RESET(reset),
        .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
        .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
        .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
        .TRIGGER(trigger), .SAMPLE(sample), .PRECHARGE_TIME(precharge_time),
        .COMPUTATION_MODE_SELECT(computation_mode_select),
        .BUSY(busy), .CONV_DONE(conv_done), .SECOND_CYCLE(second_cycle),
        .PRECHARGE_ACTIVE(precharge_active), .PIN_TO_SUPPLY(pin_to_supply),
        .HOLD_TO_SUPPLY(hold_to_supply), .GUARD_LEVEL(guard_level),
        .RESULT(result), .PREVIOUS_RESULT(previous_result)
    );

    // ============================================================
    // Clock: 50 MHz, 20 ns period
    initial core_clk = 1'b0;
    always #10 core_clk = ~core_clk;

    // ============================================================
    // Verdict and comparisons
    // Single exit point for both normal end and watchdog
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // Register read data against expectation
    task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_reg

    // Converter port values and bench counts
    task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val

    // ============================================================
    // Avalon-MM master
    // Holds the request until waitrequest is seen low; the slave's latency is not assumed
    task automatic bus_cycle(input logic wr, input logic [3:0] a, input logic [7:0] d,
                             input logic [3:0] be);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= ~wr;
        // Waitrequest is looked at on rising edges only; the request stands until then
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0 && n < 50) begin
            n++;
            @(posedge core_clk);
        end
        // A hung slave counts as a mismatch
        if (n >= 50) begin
            n_fail++;
        end
        // Read data is taken at the very edge that sees waitrequest low
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus_cycle

    task automatic bus_write(input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
        bus_cycle(1'b1, a, d, be);
    endtask : bus_write

    // Read one register and compare with expectation
    task automatic bus_read(input logic [3:0] a, input logic [7:0] exp, input string what);
        bus_cycle(1'b0, a, 8'h00, 4'hF);
        chk_reg(what, {24'h000000, exp}, rd);
    endtask : bus_read

    // ============================================================
    // One triggered conversion sequence with monitoring of every cycle
    task automatic run_conv(input logic [7:0] ctrl, input logic [7:0] pt, input logic [15:0] s1,
                            input logic [15:0] s2);
        int n_st;
        int conv_cyc;
        int pre_cyc;
        int done_cnt;
        int sec_cnt;
        int i;
        logic go2;
        logic inv;
        logic [2:0] pol [2];
        n_st = ctrl[0] ? 2 : 1;
        inv = ctrl[6] & ctrl[0];
        conv_cyc = 0;
        pre_cyc = 0;
        done_cnt = 0;
        sec_cnt = 0;
        i = 0;
        go2 = 1'b0;
        pol[0] = 3'h0;
        pol[1] = 3'h0;
        bus_write(`APSR_OFF_CTRL_ONE, ctrl, 4'hF);
        @(posedge core_clk);
        precharge_time <= pt;
        sample <= s1;
        trigger <= 1'b1;
        @(posedge core_clk);
        trigger <= 1'b0;
        // Observe mid-cycle, drive on the rising edge
        while (i < 400 && !(done_cnt > 0 && busy === 1'b0)) begin
            @(negedge core_clk);
            if (busy === 1'b1 && precharge_active === 1'b0) begin
                conv_cyc++;
            end
            if (precharge_active === 1'b1) begin
                pre_cyc++;
                // Last precharge cycle of each stage wins
                pol[second_cycle === 1'b1] = {pin_to_supply, hold_to_supply, guard_level};
            end
            if (second_cycle === 1'b1) begin
                sec_cnt++;
            end
            if (conv_done === 1'b1) begin
                done_cnt++;
            end
            if (second_cycle === 1'b1 && precharge_active === 1'b1) begin
                go2 = 1'b1;
            end
            @(posedge core_clk);
            // New input value only once the second stage is under way
            if (go2) begin
                sample <= s2;
            end
            i++;
        end
        // A stray second completion pulse would show here
        repeat (3) begin
            @(negedge core_clk);
            if (conv_done === 1'b1) begin
                done_cnt++;
            end
        end
        chk_val("done pulses", 16'h0001, 16'(done_cnt));
        chk_val("conversion cycles", 16'(`APSR_CONV_CYCLES * n_st), 16'(conv_cyc));
        chk_val("precharge cycles", 16'(pt * n_st), 16'(pre_cyc));
        chk_val("result", (n_st == 2) ? s2 : s1, result);
        if (n_st == 1) begin
            chk_val("second stage cycles", 16'h0000, 16'(sec_cnt));
        end else begin
            chk_val("previous result", s1, previous_result);
        end
        if (pt != 8'h00) begin
            chk_val("first drive", {13'h0000, ctrl[7], ~ctrl[7], ctrl[5]}, {13'h0000, pol[0]});
            if (n_st == 2) begin
                chk_val("second drive", {13'h0000, ctrl[7] ^ inv, ~ctrl[7] ^ inv, ctrl[5] ^ inv},
                        {13'h0000, pol[1]});
            end
        end
    endtask : run_conv

    // ============================================================
    // Conversion table: control byte and precharge length
    logic [7:0] cfg_ctrl [8] = '{8'h00, 8'h01, 8'hE1, 8'h21, 8'h81, 8'hC0, 8'h61, 8'hA0};
    logic [7:0] cfg_pt [8] = '{8'h00, 8'h00, 8'h03, 8'h03, 8'h04, 8'h03, 8'h03, 8'h02};
    // Error upper byte per mode for result 5122, previous A011, setpoint 3C5A
    logic [7:0] err_exp [4] = '{8'hB1, 8'h14, 8'h63, 8'hEB};

    // ============================================================
    // Main sequence
    initial begin
        reset = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'h0;
        trigger = 1'b0;
        sample = 16'h0000;
        precharge_time = 8'h00;
        computation_mode_select = 3'h0;
        n_fail = 0;
        checks_done = 0;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        // Reset values
        bus_read(`APSR_OFF_CTRL_ONE, 8'h00, "control one reset");
        bus_read(`APSR_OFF_STPT_HIGH, 8'h00, "setpoint high reset");
        bus_read(`APSR_OFF_STPT_LOW, 8'h00, "setpoint low reset");
        bus_read(`APSR_OFF_ERR_HIGH, 8'h00, "error reset");
        $display("test reset values done");
        // Control one: unimplemented bits stay zero, lane 0 gates the store
        bus_write(`APSR_OFF_CTRL_ONE, 8'hFF, 4'hF);
        bus_read(`APSR_OFF_CTRL_ONE, 8'hE1, "control one all ones");
        bus_write(`APSR_OFF_CTRL_ONE, 8'h00, 4'hE);
        bus_read(`APSR_OFF_CTRL_ONE, 8'hE1, "control one lane off");
        bus_write(`APSR_OFF_CTRL_ONE, 8'h1E, 4'hF);
        bus_read(`APSR_OFF_CTRL_ONE, 8'h00, "control one reserved");
        $display("test control one done");
        // Setpoint bytes are independent and read back; error byte refuses writes
        bus_write(`APSR_OFF_STPT_HIGH, 8'hA5, 4'hF);
        bus_write(`APSR_OFF_STPT_LOW, 8'h5A, 4'hF);
        bus_read(`APSR_OFF_STPT_HIGH, 8'hA5, "setpoint high");
        bus_read(`APSR_OFF_STPT_LOW, 8'h5A, "setpoint low");
        bus_write(`APSR_OFF_STPT_HIGH, 8'h3C, 4'hF);
        bus_read(`APSR_OFF_STPT_HIGH, 8'h3C, "setpoint high rewrite");
        bus_read(`APSR_OFF_STPT_LOW, 8'h5A, "setpoint low kept");
        bus_write(`APSR_OFF_ERR_HIGH, 8'hFF, 4'hF);
        bus_read(`APSR_OFF_ERR_HIGH, 8'h00, "error read only");
        bus_read(4'h2, 8'h00, "unmapped");
        $display("test setpoint done");
        // Single and double conversions over seven of the eight polarity and inversion bit settings
        for (int k = 0; k < 8; k++) begin
            run_conv(cfg_ctrl[k], cfg_pt[k], {8'hA0 + 8'(k), 8'h11},
                     (cfg_pt[k] != 8'h00) ? {8'h50 + 8'(k), 8'hEE} : {8'hA0 + 8'(k), 8'h11});
        end
        $display("test conversions done");
        // Every computation mode, on a double sample with distinct values
        for (int m = 0; m < 4; m++) begin
            computation_mode_select <= 3'(m);
            run_conv(8'h01, 8'h03, 16'hA011, 16'h5122);
            bus_read(`APSR_OFF_ERR_HIGH, err_exp[m], "error by mode");
        end
        $display("test setpoint error done");
        report_and_stop();
    end

    // ============================================================
    // Watchdog: the whole run needs well under 3000 cycles
    initial begin
        #(20 * 20000);
        n_fail++;
        $display("watchdog expired");
        report_and_stop();
    end

endmodule : tb

`default_nettype wire
